// *** cfc_core.sv ***
// Purpose: flag, interrupt mask and low-power core of an 8-bit processor
// Assumes: instructions arrive already fetched as opcode plus operand
// Notes: stacked flags kept in a small memory, by stack pointer low bits
`timescale 1ns/1ns
`default_nettype none
module cfc_core (
   input  wire logic                sys_clk_i,
   input  wire logic                rst_i,
   input  wire cfc_pkg::cfc_instr_t instr_i,
   input  wire logic [7:0]          mem_data_i,
   input  wire logic [3:0]          irq_req_i,
   input  wire logic                ext_irq_i,
   input  wire logic                break_req_i,
   input  wire logic                monitor_mode_i,
   output logic                     instr_ready_o,
   output logic                     instr_done_o,
   output logic [7:0]               mem_result_o,
   output logic [7:0]               flag_register_o,
   output logic [7:0]               acc_o,
   output logic [15:0]              index_o,
   output logic [15:0]              sp_o,
   output logic [15:0]              pc_o,
   output logic [7:0]               ireg_o,
   output logic                     in_break_o,
   output logic                     core_clk_run_o,
   output logic [1:0]               irq_ack_o
);
   cfc_pkg::cfc_core_t r;
   cfc_pkg::cfc_core_t next_r;
   logic [3:0]  irq_s1;
   logic [3:0]  irq_s2;
   logic [1:0]  ext_s;
   logic [1:0]  brk_s;
   logic [1:0]  ack;
   logic [1:0]  next_ack;
   logic [7:0]  mres;
   logic [7:0]  stk_rdata;
   logic        stk_we;
   logic        irq_pend;
   logic [1:0]  irq_sel;
   logic        brk;
   logic [7:0]  op;
   logic [1:0]  mon_s;
   logic [7:0]  sh_src;
   logic [7:0]  sh_res;

   // pin synchronisers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_s1 <= 4'h0;
         irq_s2 <= 4'h0;
         ext_s  <= 2'h0;
         brk_s  <= 2'h0;
         mon_s  <= 2'h0;
      end else begin
         irq_s1 <= irq_req_i;
         irq_s2 <= irq_s1;
         ext_s  <= {ext_s[0], ext_irq_i};
         brk_s  <= {brk_s[0], break_req_i};
         mon_s  <= {mon_s[0], monitor_mode_i};
      end
   end

   assign brk      = brk_s[1];
   assign irq_pend = (|irq_s2) & ~r.flags[cfc_pkg::FLAG_I];

   // lowest index wins
   always_comb begin
      irq_sel = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (irq_s2[i]) begin
            irq_sel = 2'(i);
         end
      end
   end

   assign stk_we = (r.state == cfc_pkg::CFC_STACK) && (r.cyc == cfc_pkg::CYC_STACKING);

   cfc_stack_mem u_stack (
      .sys_clk_i (sys_clk_i),
      .we_i      (stk_we),
      .waddr_i   (r.sp[3:0]),
      .wdata_i   (r.flags),
      .raddr_i   (r.sp[3:0] + 4'h1),
      .rdata_o   (stk_rdata)
   );

   assign op = instr_i.opcode;

   always_comb begin
      next_r      = r;
      next_ack    = ack;
      next_r.done = 1'b0;
      mres        = mem_result_o;
      sh_src      = 8'h00;
      sh_res      = 8'h00;
      next_r.flags = r.flags | cfc_pkg::FLAG_FIXED_ONES;
      case (r.state)
         cfc_pkg::CFC_RUN: begin
            next_r.busy = 1'b0;
            if (brk && !r.in_break) begin
               // instructions complete in one step, so boundary is now
               next_r.ireg     = cfc_pkg::OP_SOFTWARE_TRAP;
               next_r.in_break = 1'b1;
               next_r.state    = cfc_pkg::CFC_STACK;
               next_r.cyc      = 4'h1;
            end else if (irq_pend) begin
               next_ack     = irq_sel;
               next_r.state = cfc_pkg::CFC_STACK;
               next_r.cyc   = 4'h1;
            end else if (instr_i.valid) begin
               next_r.ireg = op;
               next_r.done = 1'b1;
               next_r.pc   = r.pc + 16'h0001;
               if (op == cfc_pkg::OP_SP_PREFIX && !r.pfx) begin
                  next_r.pfx  = 1'b1;
                  next_r.done = 1'b0;
               end else begin
                  next_r.pfx = 1'b0;
                  case (op)
                     cfc_pkg::OP_STACK_ADD: begin
                        next_r.sp = r.sp + {{8{instr_i.operand[7]}}, instr_i.operand};
                     end
                     cfc_pkg::OP_INDEX_ADD: begin
                        {next_r.xhi, next_r.xlo} = {r.xhi, r.xlo}
                           + {{8{instr_i.operand[7]}}, instr_i.operand};
                     end
                     cfc_pkg::OP_BR_NO_CARRY: begin
                        next_r.pc = r.pc + 16'h0002;
                        if (!r.flags[cfc_pkg::FLAG_C]) begin
                           next_r.pc = r.pc + 16'h0002 + {{8{instr_i.operand[7]}}, instr_i.operand};
                        end
                     end
                     cfc_pkg::OP_SHL_DIR, cfc_pkg::OP_SHL_ACC, cfc_pkg::OP_SHL_XLO,
                     cfc_pkg::OP_SHL_IX1, cfc_pkg::OP_SHL_IX: begin
                        sh_src = (op == cfc_pkg::OP_SHL_ACC) ? r.acc :
                                 (op == cfc_pkg::OP_SHL_XLO) ? r.xlo : mem_data_i;
                        sh_res = {sh_src[6:0], 1'b0};
                        if (op == cfc_pkg::OP_SHL_ACC) next_r.acc = sh_res;
                        else if (op == cfc_pkg::OP_SHL_XLO) next_r.xlo = sh_res;
                        else mres = sh_res;
                        next_r.flags[cfc_pkg::FLAG_C] = sh_src[7];
                        next_r.flags[cfc_pkg::FLAG_N] = sh_res[7];
                        next_r.flags[cfc_pkg::FLAG_Z] = (sh_res == 8'h00);
                        next_r.flags[cfc_pkg::FLAG_V] = sh_res[7] ^ sh_src[7];
                     end
                     cfc_pkg::OP_SHR_DIR, cfc_pkg::OP_SHR_ACC, cfc_pkg::OP_SHR_XLO,
                     cfc_pkg::OP_SHR_IX1, cfc_pkg::OP_SHR_IX: begin
                        sh_src = (op == cfc_pkg::OP_SHR_ACC) ? r.acc :
                                 (op == cfc_pkg::OP_SHR_XLO) ? r.xlo : mem_data_i;
                        sh_res = {sh_src[7], sh_src[7:1]};
                        if (op == cfc_pkg::OP_SHR_ACC) next_r.acc = sh_res;
                        else if (op == cfc_pkg::OP_SHR_XLO) next_r.xlo = sh_res;
                        else mres = sh_res;
                        next_r.flags[cfc_pkg::FLAG_C] = sh_src[0];
                        next_r.flags[cfc_pkg::FLAG_N] = sh_res[7];
                        next_r.flags[cfc_pkg::FLAG_Z] = (sh_res == 8'h00);
                        next_r.flags[cfc_pkg::FLAG_V] = sh_res[7] ^ sh_src[0];
                     end
                     cfc_pkg::OP_UNMASK: begin
                        next_r.flags[cfc_pkg::FLAG_I] = 1'b0;
                     end
                     cfc_pkg::OP_RETURN: begin
                        next_r.state = cfc_pkg::CFC_UNSTK;
                        next_r.cyc   = 4'h1;
                        next_r.done  = 1'b0;
                     end
                     cfc_pkg::OP_WAIT: begin
                        next_r.flags[cfc_pkg::FLAG_I] = 1'b0;
                        next_r.clk_run = 1'b0;
                        next_r.state   = cfc_pkg::CFC_WAIT;
                     end
                     cfc_pkg::OP_STOP: begin
                        next_r.flags[cfc_pkg::FLAG_I] = 1'b0;
                        next_r.clk_run = 1'b0;
                        next_r.state   = cfc_pkg::CFC_STOP;
                     end
                     default: begin
                        next_r.done = 1'b1;
                     end
                  endcase
               end
            end
         end
         cfc_pkg::CFC_STACK: begin
            next_r.busy = 1'b1;
            next_r.cyc  = r.cyc + 4'h1;
            // only flags pushed; upper index byte left alone
            if (r.cyc == cfc_pkg::CYC_STACKING) begin
               next_r.sp    = r.sp - 16'h0001;
               next_r.flags[cfc_pkg::FLAG_I] = 1'b1;
               next_r.state = cfc_pkg::CFC_VECTOR;
            end
         end
         cfc_pkg::CFC_VECTOR: begin
            next_r.pc = r.in_break && r.ireg == cfc_pkg::OP_SOFTWARE_TRAP
                        ? (mon_s[1] ? cfc_pkg::VEC_BREAK_MON : cfc_pkg::VEC_BREAK)
                        : cfc_pkg::VEC_IRQ - {13'h0000, ack, 1'b0};
            next_r.state = cfc_pkg::CFC_RUN;
            next_r.ireg  = 8'h00;
         end
         cfc_pkg::CFC_UNSTK: begin
            next_r.busy = 1'b1;
            next_r.cyc  = r.cyc + 4'h1;
            if (r.cyc == cfc_pkg::CYC_UNSTACKING) begin
               next_r.flags = stk_rdata | cfc_pkg::FLAG_FIXED_ONES;
               next_r.sp    = r.sp + 16'h0001;
               next_r.state = cfc_pkg::CFC_RUN;
               next_r.done  = 1'b1;
               if (!brk) begin
                  next_r.in_break = 1'b0;
               end
            end
         end
         cfc_pkg::CFC_WAIT: begin
            if (irq_pend || brk) begin
               next_r.clk_run = 1'b1;
               next_r.state   = cfc_pkg::CFC_RUN;
            end
         end
         cfc_pkg::CFC_STOP: begin
            if (ext_s[1]) begin
               next_r.state  = cfc_pkg::CFC_SETTLE;
               next_r.settle = 16'h0000;
            end
         end
         cfc_pkg::CFC_SETTLE: begin
            next_r.settle = r.settle + 16'h0001;
            if (r.settle == 16'(cfc_pkg::OSC_SETTLE_CYC - 1)) begin
               next_r.clk_run = 1'b1;
               next_r.state   = cfc_pkg::CFC_RUN;
            end
         end
         default: begin
            next_r.state = cfc_pkg::CFC_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r              <= '0;
         r.state        <= cfc_pkg::CFC_RUN;
         r.sp           <= cfc_pkg::RESET_SP;
         r.pc           <= cfc_pkg::RESET_PC;
         r.flags        <= cfc_pkg::RESET_FLAGS;
         r.clk_run      <= 1'b1;
         ack            <= 2'h0;
         mem_result_o   <= 8'h00;
      end else begin
         r            <= next_r;
         ack          <= next_ack;
         mem_result_o <= mres;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         instr_ready_o   <= 1'b0;
         instr_done_o    <= 1'b0;
         flag_register_o <= cfc_pkg::RESET_FLAGS;
         acc_o           <= 8'h00;
         index_o         <= 16'h0000;
         sp_o            <= cfc_pkg::RESET_SP;
         pc_o            <= cfc_pkg::RESET_PC;
         ireg_o          <= 8'h00;
         in_break_o      <= 1'b0;
         core_clk_run_o  <= 1'b1;
         irq_ack_o       <= 2'h0;
      end else begin
         instr_ready_o   <= (next_r.state == cfc_pkg::CFC_RUN);
         instr_done_o    <= next_r.done;
         flag_register_o <= next_r.flags;
         acc_o           <= next_r.acc;
         index_o         <= {next_r.xhi, next_r.xlo};
         sp_o            <= next_r.sp;
         pc_o            <= next_r.pc;
         ireg_o          <= next_r.ireg;
         in_break_o      <= next_r.in_break;
         core_clk_run_o  <= next_r.clk_run;
         irq_ack_o       <= next_ack;
      end
   end

   property p_mask_blocks;
      @(posedge sys_clk_i) disable iff (rst_i)
      (r.state == cfc_pkg::CFC_RUN && r.flags[cfc_pkg::FLAG_I] && !brk) |=> (r.state != cfc_pkg::CFC_STACK);
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("masked request taken");

   property p_mask_after_stack;
      @(posedge sys_clk_i) disable iff (rst_i)
      (r.state == cfc_pkg::CFC_STACK && r.cyc == cfc_pkg::CYC_STACKING) |=>
         (r.flags[cfc_pkg::FLAG_I] && r.state == cfc_pkg::CFC_VECTOR);
   endproperty
   a_mask_after_stack: assert property (p_mask_after_stack) else $error("mask not set before vector");

   property p_index_hi_kept;
      @(posedge sys_clk_i) disable iff (rst_i)
      (r.state == cfc_pkg::CFC_STACK) |=> $stable(r.xhi);
   endproperty
   a_index_hi_kept: assert property (p_index_hi_kept) else $error("upper index changed on entry");

   property p_fixed_ones;
      @(posedge sys_clk_i) disable iff (rst_i)
      1'b1 |-> (flag_register_o[6:5] == 2'b11);
   endproperty
   a_fixed_ones: assert property (p_fixed_ones) else $error("fixed flag bits not one");

   property p_stack_add;
      @(posedge sys_clk_i) disable iff (rst_i)
      (r.state == cfc_pkg::CFC_RUN && !brk && !irq_pend && instr_i.valid && !r.pfx
       && instr_i.opcode == cfc_pkg::OP_STACK_ADD)
      |=> (r.sp == $past(r.sp) + {{8{$past(instr_i.operand[7])}}, $past(instr_i.operand)})
          && (r.flags == $past(r.flags));
   endproperty
   a_stack_add: assert property (p_stack_add) else $error("stack add wrong");

   property p_branch;
      @(posedge sys_clk_i) disable iff (rst_i)
      (r.state == cfc_pkg::CFC_RUN && !brk && !irq_pend && instr_i.valid && !r.pfx
       && instr_i.opcode == cfc_pkg::OP_BR_NO_CARRY && r.flags[cfc_pkg::FLAG_C])
      |=> (r.pc == $past(r.pc) + 16'h0002);
   endproperty
   a_branch: assert property (p_branch) else $error("branch taken with carry set");

   property p_settle;
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(r.state == cfc_pkg::CFC_SETTLE) |-> !r.clk_run [*8];
   endproperty
   a_settle: assert property (p_settle) else $error("clock resumed before settle");

   property p_wait_clear;
      @(posedge sys_clk_i) disable iff (rst_i)
      (r.state == cfc_pkg::CFC_WAIT) |-> (!r.flags[cfc_pkg::FLAG_I] && !r.clk_run);
   endproperty
   a_wait_clear: assert property (p_wait_clear) else $error("wait state mask or clock wrong");
endmodule
`default_nettype wire

// *** cfc_partner.sv ***
// Purpose: far side model: instruction feed, request lines, break logic
// Assumes: changes at the falling clock edge, except idle opcode lines at the rising edge
// Notes: idle opcode lines toggle every cycle
`timescale 1ns/1ns
`default_nettype none
module cfc_partner (
   input  wire logic               sys_clk_i,
   input  wire logic               ready_i,
   output var cfc_pkg::cfc_instr_t instr_o,
   output logic [7:0]              mem_o,
   output logic [3:0]              irq_o,
   output logic                    ext_o,
   output logic                    brk_o,
   output logic                    mon_o
);
   logic       vld = 1'b0;
   logic [7:0] op;
   logic [7:0] opd;
   logic [7:0] pat = 8'h5a;
   always @(posedge sys_clk_i) pat <= ~pat;
   assign instr_o = vld ? {1'b1, op, opd} : {1'b0, pat, ~pat};
   initial begin
      irq_o = 4'h0;
      ext_o = 1'b0;
      brk_o = 1'b0;
      mon_o = 1'b0;
      mem_o = 8'h00;
   end
   // hold the instruction until ready is seen at an edge
   task automatic issue(input logic [7:0] o, input logic [7:0] d, output bit ok);
      int n;
      n = 0;
      @(negedge sys_clk_i);
      vld = 1'b1;
      op = o;
      opd = d;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (ready_i !== 1'b1 && n < 60);
      ok = (ready_i === 1'b1);
      @(negedge sys_clk_i);
      vld = 1'b0;
   endtask
   task automatic lines(input logic [3:0] i, input logic e, b, m, input logic [7:0] d);
      @(negedge sys_clk_i);
      irq_o = i;
      ext_o = e;
      brk_o = b;
      mon_o = m;
      mem_o = d;
   endtask
endmodule
`default_nettype wire

// *** cfc_pkg.sv ***
// Purpose: shared constants and types for the flag and interrupt core
// Assumes: 8-bit core on the bus clock
// Notes: opcode values and cycle counts of the covered instructions
package cfc_pkg;
   localparam logic [7:0]  OP_STACK_ADD      = 8'ha7;
   localparam logic [7:0]  OP_INDEX_ADD      = 8'haf;
   localparam logic [7:0]  OP_BR_NO_CARRY    = 8'h24;
   localparam logic [7:0]  OP_SHL_DIR        = 8'h38;
   localparam logic [7:0]  OP_SHL_ACC        = 8'h48;
   localparam logic [7:0]  OP_SHL_XLO        = 8'h58;
   localparam logic [7:0]  OP_SHL_IX1        = 8'h68;
   localparam logic [7:0]  OP_SHL_IX         = 8'h78;
   localparam logic [7:0]  OP_SHR_DIR        = 8'h37;
   localparam logic [7:0]  OP_SHR_ACC        = 8'h47;
   localparam logic [7:0]  OP_SHR_XLO        = 8'h57;
   localparam logic [7:0]  OP_SHR_IX1        = 8'h67;
   localparam logic [7:0]  OP_SHR_IX         = 8'h77;
   localparam logic [7:0]  OP_SP_PREFIX      = 8'h9e;
   localparam logic [7:0]  OP_SOFTWARE_TRAP  = 8'h83;
   localparam logic [7:0]  OP_UNMASK         = 8'h9a;
   localparam logic [7:0]  OP_RETURN         = 8'h80;
   localparam logic [7:0]  OP_WAIT           = 8'h8f;
   localparam logic [7:0]  OP_STOP           = 8'h8e;
   localparam logic [15:0] VEC_BREAK         = 16'hfffc;
   localparam logic [15:0] VEC_BREAK_MON     = 16'hfefc;
   localparam logic [15:0] VEC_IRQ           = 16'hfffa;
   localparam logic [15:0] RESET_SP          = 16'h00ff;
   localparam logic [15:0] RESET_PC          = 16'h0000;
   localparam logic [7:0]  RESET_FLAGS       = 8'h68;
   localparam int          FLAG_C            = 0;
   localparam int          FLAG_Z            = 1;
   localparam int          FLAG_N            = 2;
   localparam int          FLAG_I            = 3;
   localparam int          FLAG_V            = 7;
   localparam logic [7:0]  FLAG_FIXED_ONES   = 8'h60;
   localparam logic [3:0]  CYC_IMM_ADD       = 4'h2;
   localparam logic [3:0]  CYC_BRANCH        = 4'h3;
   localparam logic [3:0]  CYC_SHIFT_REG     = 4'h1;
   localparam logic [3:0]  CYC_STACKING      = 4'h4;
   localparam logic [3:0]  CYC_UNSTACKING    = 4'h4;
   localparam int          OSC_SETTLE_NS     = 40960;
   localparam int          CLK_PERIOD_NS     = 10;
   localparam int          OSC_SETTLE_CYC    = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      CFC_RUN    = 3'b000,
      CFC_STACK  = 3'b001,
      CFC_VECTOR = 3'b010,
      CFC_UNSTK  = 3'b011,
      CFC_WAIT   = 3'b100,
      CFC_STOP   = 3'b101,
      CFC_SETTLE = 3'b110
   } cfc_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] opcode;
      logic [7:0] operand;
   } cfc_instr_t;

   typedef struct packed {
      cfc_state_t  state;
      logic [7:0]  acc;
      logic [7:0]  xlo;
      logic [7:0]  xhi;
      logic [15:0] sp;
      logic [15:0] pc;
      logic [7:0]  flags;
      logic [7:0]  ireg;
      logic [3:0]  cyc;
      logic [15:0] settle;
      logic        in_break;
      logic        busy;
      logic        done;
      logic        clk_run;
      logic [7:0]  saved_flags;
      logic        pfx;
   } cfc_core_t;
endpackage

// *** cfc_stack_mem.sv ***
// Purpose: small stack memory with registered read data
// Assumes: single clock, one write and one read port
// Notes: holds saved flag register bytes
`timescale 1ns/1ns
`default_nettype none
module cfc_stack_mem (
   input  wire logic       sys_clk_i,
   input  wire logic       we_i,
   input  wire logic [3:0] waddr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [3:0] raddr_i,
   output logic      [7:0] rdata_o
);
   logic [7:0] mem [0:15];

   always_ff @(posedge sys_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule
`default_nettype wire

// *** cpu_flags_interrupt_mask_core_ops_test.sv ***
// Purpose: self-checking bench for the flag and interrupt core
// Assumes: partner feeds instructions, bench keeps a reference model
// Notes: branch target taken from pc seen before issue
`timescale 1ns/1ns
`default_nettype none
module cpu_flags_interrupt_mask_core_ops_test;
   logic                sys_clk_i = 1'b0;
   logic                rst_i     = 1'b1;
   cfc_pkg::cfc_instr_t instr;
   logic [7:0]          mem, mem_res, flags, acc, ireg, m_fl, m_acc, d, r, s;
   logic [3:0]          irq;
   logic                ext, brk, mon, rdy, done, inb, crun;
   logic [15:0]         idx, sp, pc, m_sp, m_ix, p0;
   logic [1:0]          ack;
   int                  errors = 0;
   int                  checks = 0;
   int                  seed   = 33;
   int                  n;
   bit                  ok;
   logic [15:0]         ops[$] = '{16'h38, 16'h48, 16'h58, 16'h68, 16'h78, 16'h9e68,
                                   16'h37, 16'h47, 16'h57, 16'h67, 16'h77, 16'h9e67};
   always #5 sys_clk_i = ~sys_clk_i;
   cfc_partner prt (.sys_clk_i(sys_clk_i), .ready_i(rdy), .instr_o(instr), .mem_o(mem), .irq_o(irq),
                    .ext_o(ext), .brk_o(brk), .mon_o(mon));
   cfc_core dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_i(instr), .mem_data_i(mem), .irq_req_i(irq),
                 .ext_irq_i(ext), .break_req_i(brk), .monitor_mode_i(mon), .instr_ready_o(rdy),
                 .instr_done_o(done), .mem_result_o(mem_res), .flag_register_o(flags), .acc_o(acc),
                 .index_o(idx), .sp_o(sp), .pc_o(pc), .ireg_o(ireg), .in_break_o(inb),
                 .core_clk_run_o(crun), .irq_ack_o(ack));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic fail_out();
      errors++;
      conclude();
   endtask
   function automatic logic [15:0] pick(input int sel);
      case (sel)
         0: return 16'(done);
         1: return pc;
         2: return 16'(crun);
         default: return 16'(inb);
      endcase
   endfunction
   task automatic wait_for(input int sel, input logic [15:0] v, input int lim);
      n = 0;
      while (pick(sel) !== v && n < lim) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (n >= lim) fail_out();
   endtask
   task automatic run(input logic [7:0] o, input logic [7:0] v);
      prt.issue(o, v, ok);
      if (!ok) fail_out();
      if (o != cfc_pkg::OP_SP_PREFIX) wait_for(0, 16'h1, 20);
      @(negedge sys_clk_i);
   endtask
   task automatic do_reset();
      rst_i = 1'b1;
      repeat (6) @(negedge sys_clk_i);
      rst_i = 1'b0;
      m_fl = cfc_pkg::RESET_FLAGS;
      m_sp = cfc_pkg::RESET_SP;
      m_ix = 16'h0000;
      m_acc = 8'h00;
      repeat (2) @(negedge sys_clk_i);
   endtask
   // shift model: updates carry, negative, zero and overflow
   function automatic logic [7:0] shf(input logic [7:0] x, input bit left);
      logic [7:0] y;
      y = left ? {x[6:0], 1'b0} : {x[7], x[7:1]};
      m_fl[0] = left ? x[7] : x[0];
      m_fl[2] = y[7];
      m_fl[1] = (y == 8'h00);
      m_fl[7] = y[7] ^ m_fl[0];
      return y;
   endfunction
   initial begin
      do_reset();
      check(16'(flags), 16'h0068);
      check(sp, m_sp);
      for (int i = 0; i < 6; i++) begin
         d = (i < 2) ? 8'h7f + 8'(i) : 8'($random(seed));
         run(cfc_pkg::OP_STACK_ADD, d);
         m_sp = m_sp + {{8{d[7]}}, d};
         check(sp, m_sp);
         run(cfc_pkg::OP_INDEX_ADD, d);
         m_ix = m_ix + {{8{d[7]}}, d};
         check(idx, m_ix);
         check(16'(flags), 16'(m_fl));
      end
      $display("test immediate adds done");
      foreach (ops[k]) begin
         d = 8'($random(seed));
         prt.lines(4'h0, 1'b0, 1'b0, 1'b0, d);
         s = (ops[k][7:4] == 4'h4) ? m_acc : (ops[k][7:4] == 4'h5) ? m_ix[7:0] : d;
         r = shf(s, ops[k][3]);
         if (ops[k][15:8] == cfc_pkg::OP_SP_PREFIX) run(cfc_pkg::OP_SP_PREFIX, 8'h00);
         run(ops[k][7:0], 8'h10);
         if (ops[k][7:4] == 4'h4) m_acc = r;
         if (ops[k][7:4] == 4'h5) m_ix[7:0] = r;
         s = (ops[k][7:4] == 4'h4) ? acc : (ops[k][7:4] == 4'h5) ? idx[7:0] : mem_res;
         check(16'(s), 16'(r));
         check(16'(flags), 16'(m_fl));
         p0 = pc;
         d = 8'($random(seed));
         run(cfc_pkg::OP_BR_NO_CARRY, d);
         check(pc, p0 + 16'h0002 + (m_fl[0] ? 16'h0000 : {{8{d[7]}}, d}));
         check(16'(flags), 16'(m_fl));
      end
      $display("test shifts and branches done");
      p0 = pc;
      prt.lines(4'b0110, 1'b0, 1'b0, 1'b0, 8'h00);
      repeat (10) @(negedge sys_clk_i);
      check(pc, p0);
      prt.lines(4'h0, 1'b0, 1'b0, 1'b0, 8'h00);
      run(cfc_pkg::OP_UNMASK, 8'h00);
      m_fl[3] = 1'b0;
      check(16'(flags), 16'(m_fl));
      p0 = sp;
      prt.lines(4'b0110, 1'b0, 1'b0, 1'b0, 8'h00);
      wait_for(1, 16'hfff8, 30);
      check(16'(flags), 16'(m_fl | 8'h08));
      check(16'(ack), 16'h0001);
      check(idx, m_ix);
      prt.lines(4'h0, 1'b0, 1'b0, 1'b0, 8'h00);
      run(cfc_pkg::OP_RETURN, 8'h00);
      check(16'(flags), 16'(m_fl));
      check(sp, p0);
      $display("test requests done");
      do_reset();
      prt.issue(cfc_pkg::OP_WAIT, 8'h00, ok);
      if (!ok) fail_out();
      wait_for(2, 16'h0, 20);
      m_fl[3] = 1'b0;
      check(16'(flags), 16'(m_fl));
      prt.lines(4'b0001, 1'b0, 1'b0, 1'b0, 8'h00);
      wait_for(1, 16'hfffa, 30);
      check(16'(crun), 16'h0001);
      prt.lines(4'h0, 1'b0, 1'b0, 1'b0, 8'h00);
      run(cfc_pkg::OP_RETURN, 8'h00);
      check(16'(flags), 16'(m_fl));
      do_reset();
      prt.issue(cfc_pkg::OP_STOP, 8'h00, ok);
      if (!ok) fail_out();
      wait_for(2, 16'h0, 20);
      check(16'(flags), 16'(m_fl & 8'hf7));
      prt.lines(4'h0, 1'b1, 1'b0, 1'b0, 8'h00);
      wait_for(2, 16'h1, 5000);
      check(16'(n >= cfc_pkg::OSC_SETTLE_CYC && n < cfc_pkg::OSC_SETTLE_CYC + 10), 16'h0001);
      check(16'(flags), 16'(m_fl & 8'hf7));
      prt.lines(4'h0, 1'b0, 1'b0, 1'b0, 8'h00);
      prt.issue(cfc_pkg::OP_WAIT, 8'h00, ok);
      if (!ok) fail_out();
      wait_for(2, 16'h0, 20);
      do_reset();
      check(16'(flags), 16'h0068);
      $display("test low power done");
      for (int m = 0; m < 2; m++) begin
         prt.lines(4'h0, 1'b0, 1'b1, m[0], 8'h00);
         wait_for(3, 16'h1, 20);
         check(16'(ireg), 16'(cfc_pkg::OP_SOFTWARE_TRAP));
         wait_for(1, m[0] ? cfc_pkg::VEC_BREAK_MON : cfc_pkg::VEC_BREAK, 10);
         check(pc, m[0] ? cfc_pkg::VEC_BREAK_MON : cfc_pkg::VEC_BREAK);
         prt.lines(4'h0, 1'b0, 1'b0, m[0], 8'h00);
         run(cfc_pkg::OP_RETURN, 8'h00);
         check(16'(inb), 16'h0000);
      end
      $display("test break done");
      conclude();
   end
endmodule
`default_nettype wire
